// *** ill_cfg.svh ***
// Constants for the indicator lamp logic: offsets, fields, resets, timing
`ifndef ILL_CFG_SVH
`define ILL_CFG_SVH

// Sizes
`define ILL_LAMPS 8
`define ILL_SLOTS 5
`define ILL_ALARMS 32
`define ILL_IDX_W 5

// Register byte offsets
`define ILL_ADR_CTRL 8'h00
`define ILL_ADR_STATUS 8'h04
`define ILL_ADR_ALARM 8'h08
`define ILL_ADR_LAMP_BASE 8'h40

// Control register fields
`define ILL_CTRL_ACK 0
`define ILL_CTRL_FAILS_LSB 1
`define ILL_CTRL_HEALTH_LSB 4

// Input slot fields, one byte per slot
`define ILL_SLOT_W 8
`define ILL_SLOT_INV 5
`define ILL_SLOT_EN 6

// Lamp configuration word fields
`define ILL_CFG_LATCH 8
`define ILL_CFG_ACK_EN 9
`define ILL_CFG_ACK_LSB 10
`define ILL_CFG_ACT_LSB 16
`define ILL_CFG_IDLE_LSB 20

// Reset values
`define ILL_SEL_RST 32'h0000_0040
`define ILL_CFG_RST 32'h0002_0100

// Supervision: failed reboots that make the fault final
`define ILL_REBOOT_LIMIT 2'h3

// Blink timing
`define ILL_CLK_HZ 50000000
`define ILL_BLINK_HALF_MS 250
`define ILL_BLINK_HALF_CYC (`ILL_BLINK_HALF_MS * (`ILL_CLK_HZ / 1000))

`endif

// *** ill_pkg.sv ***
// Types for the indicator lamp logic
package ill_pkg;

    // Lamp colour codes, in the order OFF, GREEN, RED, RED_FLASH, GREEN_FLASH
    typedef enum logic [2:0] {
        ILL_OFF,
        ILL_GREEN,
        ILL_RED,
        ILL_RED_FLASH,
        ILL_GREEN_FLASH
    } ill_colour_t;

    // Health lamp display states
    typedef enum logic [2:0] {
        ILL_H_BOOT,
        ILL_H_RUN,
        ILL_H_FAULT,
        ILL_H_FINAL
    } ill_health_t;

endpackage

// *** ill_lamp_logic.sv ***
// Indicator lamp logic with classic Wishbone register slave
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "ill_cfg.svh"
module ill_lamp_logic #(
    parameter int unsigned BLINK_HALF_CYC = `ILL_BLINK_HALF_CYC
) (
    input wire logic clk_i, // System clock, 50 MHz
    input wire logic rst_i, // Synchronous reset, active high
    // Wishbone slave
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte selects
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    // Alarm and acknowledge sources
    input wire logic [`ILL_ALARMS-1:0] alarm_i, // Assignable signals
    input wire logic panel_ack_i, // Front panel clear key
    input wire logic ext_ack_i, // External acknowledge signal
    // Supervision status
    input wire logic boot_done_i, // Boot finished
    input wire logic prot_active_i, // Protection running
    input wire logic sup_fault_i, // Self-supervision fault
    input wire logic reboot_fail_i, // Pulse per failed reboot
    // Persistence of latched states
    input wire logic restore_i, // Load saved latch states
    input wire logic [`ILL_LAMPS-1:0] restore_data_i, // Saved states
    output logic [`ILL_LAMPS-1:0] latched_o, // States to save
    // Lamp drives
    output logic [`ILL_LAMPS-1:0] lamp_red_o, // Red drive per lamp
    output logic [`ILL_LAMPS-1:0] lamp_green_o, // Green drive per lamp
    output logic health_red_o, // Health lamp red
    output logic health_green_o // Health lamp green
);

    logic [31:0] sel_word [`ILL_LAMPS];
    logic [31:0] cfg_word [`ILL_LAMPS];
    logic [`ILL_LAMPS-1:0] cond;
    logic [`ILL_LAMPS-1:0] shown;
    logic [`ILL_LAMPS-1:0] latched;
    logic [31:0] blink_cnt;
    logic blink;
    logic [1:0] fail_cnt;
    ill_pkg::ill_health_t health;
    ill_pkg::ill_colour_t health_colour;
    logic bus_req;
    logic bus_wr;
    logic scada_ack;
    logic global_ack;
    logic lamp_hit;
    logic [2:0] lamp_idx;
    logic [31:0] next_dat;

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Colour code to {red, green} drive
    function automatic logic [1:0] drive(input logic [2:0] code, input logic bl);
        logic [1:0] d;
        d = 2'h0;
        case (ill_pkg::ill_colour_t'(code))
            ill_pkg::ILL_GREEN: d = 2'h1;
            ill_pkg::ILL_RED: d = 2'h2;
            ill_pkg::ILL_RED_FLASH: d = {bl, 1'b0};
            ill_pkg::ILL_GREEN_FLASH: d = {1'b0, bl};
            default: d = 2'h0; // Off, and unused codes
        endcase
        return d;
    endfunction

    // Bus decode
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;
    assign lamp_hit = (wb_adr_i[7:6] == 2'(`ILL_ADR_LAMP_BASE >> 6));
    assign lamp_idx = wb_adr_i[5:3];

    // Acknowledge one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read data mux, unmapped addresses read zero
    always_comb begin
        next_dat = 32'h0;
        if (lamp_hit) begin
            next_dat = wb_adr_i[2] ? cfg_word[lamp_idx] : sel_word[lamp_idx];
        end else begin
            case (wb_adr_i)
                `ILL_ADR_CTRL: begin
                    next_dat[`ILL_CTRL_FAILS_LSB +: 2] = fail_cnt;
                    next_dat[`ILL_CTRL_HEALTH_LSB +: 3] = health_colour;
                end
                `ILL_ADR_STATUS: next_dat = {16'h0, shown, latched};
                `ILL_ADR_ALARM: next_dat = alarm_i;
                default: next_dat = 32'h0;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (bus_req) begin
            wb_dat_o <= wb_we_i ? 32'h0 : next_dat;
        end
    end

    // Supervisory acknowledge, one-cycle pulse from a control write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scada_ack <= 1'b0;
        end else begin
            scada_ack <= bus_wr & (wb_adr_i == `ILL_ADR_CTRL) & wb_sel_i[0]
                         & wb_dat_i[`ILL_CTRL_ACK];
        end
    end

    // Acknowledge sources that reach every lamp
    assign global_ack = panel_ack_i | ext_ack_i | scada_ack;

    // Free-running blink shared by all lamps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt <= 32'h0;
            blink <= 1'b0;
        end else if (blink_cnt == BLINK_HALF_CYC - 32'h1) begin
            blink_cnt <= 32'h0;
            blink <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // Consecutive failed reboots, cleared by a healthy run unless held at the limit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fail_cnt <= 2'h0;
        end else if (reboot_fail_i && fail_cnt != `ILL_REBOOT_LIMIT) begin
            fail_cnt <= fail_cnt + 2'h1;
        end else if (boot_done_i && prot_active_i && !sup_fault_i
                     && fail_cnt != `ILL_REBOOT_LIMIT) begin
            fail_cnt <= 2'h0;
        end
    end

    // Health lamp state, fixed and not reachable from software
    always_comb begin
        if (fail_cnt == `ILL_REBOOT_LIMIT) begin
            health = ill_pkg::ILL_H_FINAL;
        end else if (sup_fault_i) begin
            health = ill_pkg::ILL_H_FAULT;
        end else if (boot_done_i && prot_active_i) begin
            health = ill_pkg::ILL_H_RUN;
        end else begin
            health = ill_pkg::ILL_H_BOOT;
        end
    end

    // Health state to colour
    always_comb begin
        case (health)
            ill_pkg::ILL_H_BOOT: health_colour = ill_pkg::ILL_GREEN_FLASH;
            ill_pkg::ILL_H_RUN: health_colour = ill_pkg::ILL_GREEN;
            ill_pkg::ILL_H_FAULT: health_colour = ill_pkg::ILL_RED;
            ill_pkg::ILL_H_FINAL: health_colour = ill_pkg::ILL_RED_FLASH;
            default: health_colour = ill_pkg::ILL_RED;
        endcase
    end

    // Health lamp drive registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            health_red_o <= 1'b0;
            health_green_o <= 1'b0;
        end else begin
            {health_red_o, health_green_o} <= drive(health_colour, blink);
        end
    end

    // Per-lamp configuration, combining, latching and drive
    for (genvar k = 0; k < `ILL_LAMPS; k++) begin : g_lamp
        logic [`ILL_SLOTS-1:0] hit;
        logic [7:0] slot [`ILL_SLOTS];
        logic latch_en;
        logic ack_local;
        logic [2:0] colour;

        // Slot bytes: four in the select word, the fifth in the config word
        assign slot[0] = sel_word[k][7:0];
        assign slot[1] = sel_word[k][15:8];
        assign slot[2] = sel_word[k][23:16];
        assign slot[3] = sel_word[k][31:24];
        assign slot[4] = cfg_word[k][7:0];

        // Enabled, polarity-adjusted inputs
        for (genvar s = 0; s < `ILL_SLOTS; s++) begin : g_slot
            assign hit[s] = slot[s][`ILL_SLOT_EN]
                & (alarm_i[slot[s][`ILL_IDX_W-1:0]] ^ slot[s][`ILL_SLOT_INV]);
        end

        assign cond[k] = |hit;
        assign latch_en = cfg_word[k][`ILL_CFG_LATCH];
        // Own acknowledge source only counts while latching
        assign ack_local = latch_en & cfg_word[k][`ILL_CFG_ACK_EN]
            & alarm_i[cfg_word[k][`ILL_CFG_ACK_LSB +: `ILL_IDX_W]];

        // Configuration registers for this lamp
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sel_word[k] <= `ILL_SEL_RST;
                cfg_word[k] <= `ILL_CFG_RST;
            end else if (bus_wr && lamp_hit && lamp_idx == 3'(k)) begin
                if (wb_adr_i[2]) begin
                    cfg_word[k] <= merge(cfg_word[k], wb_dat_i, wb_sel_i);
                end else begin
                    sel_word[k] <= merge(sel_word[k], wb_dat_i, wb_sel_i);
                end
            end
        end

        // Latch: restore first; with latching enabled set wins, and an acknowledge clears only once all inputs are gone
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                latched[k] <= 1'b0;
            end else if (restore_i) begin
                latched[k] <= restore_data_i[k];
            end else if (!latch_en) begin
                latched[k] <= 1'b0;
            end else if (cond[k]) begin
                latched[k] <= 1'b1;
            end else if (global_ack || ack_local) begin
                latched[k] <= 1'b0;
            end
        end

        assign shown[k] = cond[k] | latched[k];
        assign colour = shown[k] ? cfg_word[k][`ILL_CFG_ACT_LSB +: 3]
                                 : cfg_word[k][`ILL_CFG_IDLE_LSB +: 3];

        // Lamp drive registers
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                lamp_red_o[k] <= 1'b0;
                lamp_green_o[k] <= 1'b0;
            end else begin
                {lamp_red_o[k], lamp_green_o[k]} <= drive(colour, blink);
            end
        end
    end

    assign latched_o = latched;

endmodule // ill_lamp_logic

// *** ill_lamp_logic_properties.sv ***
// Assertions on the lamp logic ports, bound to the design
`timescale 1ns/1ps
`include "ill_cfg.svh"
module ill_lamp_checker (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Ack
    input wire logic [`ILL_ALARMS-1:0] alarm_i, // Alarms
    input wire logic panel_ack_i, // Panel ack
    input wire logic ext_ack_i, // External ack
    input wire logic boot_done_i, // Booted
    input wire logic prot_active_i, // Protecting
    input wire logic sup_fault_i, // Fault
    input wire logic reboot_fail_i, // Failed reboot
    input wire logic restore_i, // Restore
    input wire logic [`ILL_LAMPS-1:0] restore_data_i, // Saved states
    input wire logic [`ILL_LAMPS-1:0] latched_o, // Latches
    input wire logic [`ILL_LAMPS-1:0] lamp_red_o, // Red
    input wire logic [`ILL_LAMPS-1:0] lamp_green_o, // Green
    input wire logic health_red_o, // Health red
    input wire logic health_green_o // Health green
);
    logic [1:0] rst_q; // Reset history
    logic seen_fail; // Failed reboot seen
    logic ok; // Past the reset edges

    // Track reset release and reboot failures
    always_ff @(posedge clk_i) begin
        rst_q <= {rst_q[0], rst_i};
        if (rst_i) begin
            seen_fail <= 1'b0;
        end else if (reboot_fail_i) begin
            seen_fail <= 1'b1;
        end
    end
    assign ok = rst_q == 2'b00;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus request, and a spell with no write, acknowledge or restore
    sequence s_request;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_quiet;
        ok && !wb_stb_i ##1 !wb_stb_i && !panel_ack_i && !ext_ack_i && !restore_i
            && (alarm_i == '0);
    endsequence

    a_ack_answer: assert property (s_request |=> wb_ack_o)
        else $error("Request not answered");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack too long");
    a_health_boot: assert property (ok && !boot_done_i && !sup_fault_i && !seen_fail
        |=> !health_red_o) else $error("Red while booting");
    a_health_run: assert property (ok && boot_done_i && prot_active_i
        && !sup_fault_i && !seen_fail |=> health_green_o && !health_red_o)
        else $error("Health not green");
    a_health_fault: assert property (ok && sup_fault_i && !seen_fail
        |=> health_red_o && !health_green_o) else $error("Fault not red");
    a_colour_single: assert property (((lamp_red_o & lamp_green_o) == '0)
        && !(health_red_o && health_green_o)) else $error("Two colours at once");
    a_latch_holds: assert property (s_quiet
        |=> (latched_o & $past(latched_o)) == $past(latched_o)) else $error("Latch lost");
    a_restore_load: assert property (ok && restore_i
        |=> latched_o == $past(restore_data_i)) else $error("Restore missed");
endmodule // ill_lamp_checker

bind ill_lamp_logic ill_lamp_checker u_ill_lamp_checker (.*);

// *** tb_ill_lamp_logic.sv ***
// Self-checking bench for the indicator lamp logic
`timescale 1ns/1ps
module tb_ill_lamp_logic;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, panel_ack_i, ext_ack_i;
    logic boot_done_i, prot_active_i, sup_fault_i, reboot_fail_i, restore_i;
    logic health_red_o, health_green_o;
    logic [3:0] wb_sel_i;
    logic [7:0] wb_adr_i, restore_data_i, latched_o, lamp_red_o, lamp_green_o;
    logic [31:0] wb_dat_i, wb_dat_o, alarm_i;
    int errors, cmp_count;
    // Red and green counts over 16 cycles per colour code
    logic [31:0] col_exp [5] = '{32'h0, 32'h10, 32'h10_0000, 32'h8_0000, 32'h8};

    ill_lamp_logic #(.BLINK_HALF_CYC(4)) u_ill_lamp_logic (.*);

    // Clock, 20 ns period
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle, held until ack
    task xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            errors++;
            $display("Error at %0t: ack %h expected %h", $time, wb_ack_o, 1'b1);
        end
        if (!we) chk(wb_dat_o, dat);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Count drive cycles of one lamp
    task chk_colour(input int k, input int code);
        logic [15:0] r, g;
        r = '0;
        g = '0;
        repeat (16) begin
            @(posedge clk_i);
            r += 16'(lamp_red_o[k]);
            g += 16'(lamp_green_o[k]);
        end
        chk({r, g}, col_exp[code]);
    endtask

    task give_verdict;
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        tick(20000);
        errors++;
        give_verdict();
    end

    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, panel_ack_i, ext_ack_i} = 6'h20;
        {boot_done_i, prot_active_i, sup_fault_i, reboot_fail_i, restore_i} = 5'h0;
        {wb_sel_i, wb_adr_i, wb_dat_i, alarm_i, restore_data_i} = '0;
        errors = 0;
        cmp_count = 0;
        tick(16);
        rst_i <= 1'b0;
        wb_sel_i <= 4'hf;
        tick(2);
        xfer(1'b0, 8'h40, 32'h40);
        xfer(1'b0, 8'h44, 32'h0002_0100);
        xfer(1'b0, 8'h3c, 32'h0);
        chk(32'({lamp_red_o, lamp_green_o}), 32'h0);
        alarm_i <= 32'h1;
        tick(3);
        chk(32'({lamp_red_o, lamp_green_o, latched_o}), 32'hff00ff);
        alarm_i <= 32'h0;
        tick(3);
        chk(32'({lamp_red_o, lamp_green_o, latched_o}), 32'hff00ff);
        alarm_i <= 32'h1;
        ext_ack_i <= 1'b1;
        tick(1);
        ext_ack_i <= 1'b0;
        tick(2);
        chk(32'(latched_o), 32'hff);
        alarm_i <= 32'h0;
        tick(2);
        panel_ack_i <= 1'b1;
        tick(1);
        panel_ack_i <= 1'b0;
        tick(3);
        chk(32'({lamp_red_o, lamp_green_o, latched_o}), 32'h0);
        restore_data_i <= 8'h5a;
        restore_i <= 1'b1;
        tick(1);
        restore_i <= 1'b0;
        tick(3);
        chk(32'({lamp_red_o, latched_o}), 32'h5a5a);
        panel_ack_i <= 1'b1;
        tick(1);
        panel_ack_i <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            xfer(1'b1, 8'h4c, (32'(c) << 20) | (32'(4 - c) << 16));
            alarm_i <= 32'h1;
            tick(3);
            chk_colour(1, 4 - c);
            alarm_i <= 32'h0;
            tick(3);
            chk_colour(1, c);
        end
        xfer(1'b1, 8'h50, 32'h4443_6241);
        xfer(1'b1, 8'h54, 32'h0012_0045);
        tick(2);
        chk_colour(2, 2);
        alarm_i <= 32'h4;
        tick(3);
        chk_colour(2, 1);
        alarm_i <= 32'h24;
        tick(3);
        chk_colour(2, 2);
        alarm_i <= 32'h0;
        xfer(1'b1, 8'h44, 32'h0002_1b00);
        chk(32'(latched_o), 32'hf9);
        alarm_i <= 32'h40;
        tick(3);
        chk(32'(latched_o), 32'hf8);
        alarm_i <= 32'h0;
        xfer(1'b1, 8'h00, 32'h1);
        tick(2);
        chk(32'(latched_o), 32'h0);
        xfer(1'b1, 8'h00, 32'hffff_fffe);
        xfer(1'b0, 8'h00, 32'h40);
        boot_done_i <= 1'b1;
        prot_active_i <= 1'b1;
        tick(3);
        xfer(1'b0, 8'h00, 32'h10);
        chk(32'({health_red_o, health_green_o}), 32'h1);
        sup_fault_i <= 1'b1;
        tick(3);
        xfer(1'b0, 8'h00, 32'h20);
        chk(32'({health_red_o, health_green_o}), 32'h2);
        {boot_done_i, sup_fault_i} <= 2'b00;
        repeat (3) begin
            reboot_fail_i <= 1'b1;
            tick(1);
            reboot_fail_i <= 1'b0;
            tick(1);
        end
        boot_done_i <= 1'b1;
        tick(3);
        xfer(1'b0, 8'h00, 32'h36);
        give_verdict();
    end
endmodule // tb_ill_lamp_logic
